// file: src/spcg_top.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Contract
// - Bits 7..0 gate ports A..H; set keeps clocking.
// - Clear bit stops that port's clock.
// - Access to stopped port gives bus fault.
// - Gate bits reset to zero.
// - Bits 31:8 read zero, writes ignored.
// - Sleep register governs only in Sleep.
// - Sleep gating applies only with auto-gating set.
module spcg_top
  import spcg_pkg::*;
#(
  parameter int NPORT = SPCG_NUM_PORTS
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [11:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  output logic      [1:0]       avs_response,
  input  wire logic [NPORT-1:0] port_access,
  output logic      [NPORT-1:0] port_clk_en,
  output logic                  port_bus_fault,
  output logic                  irq
);

  initial
  begin
    if (NPORT < 1 || NPORT > 8)
    begin
      $error("NPORT must lie between 1 and 8.");
    end
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [NPORT-1:0]         run_gate;
    logic [NPORT-1:0]         sleep_gate;
    logic                     auto_clock_gating_select;
    spcg_mode_t               mode;
    logic [SPCG_IRQ_BITS-1:0] stat;
    logic [SPCG_IRQ_BITS-1:0] mask;
    logic                     ack;
    logic [31:0]              rdata;
    logic [1:0]               resp;
    logic [NPORT-1:0]         gate;
    logic                     irq;
  } spcg_state_t;

  spcg_state_t st_q;
  spcg_state_t st_d;

  logic              guard_fault;
  logic [NPORT-1:0]  guard_en;
  logic              req;
  logic              wr_lane0;
  logic              wr_lane3;
  logic              hit;
  logic [31:0]       rd_word;
  logic [NPORT-1:0]  eff_gate;

  assign req      = (avs_read | avs_write) & ~st_q.ack;
  // A write lands only on the edge at which the master sees waitrequest low.
  assign wr_lane0 = avs_write & avs_byteenable[0] & st_q.ack;
  assign wr_lane3 = avs_write & avs_byteenable[3] & st_q.ack;

  // ---------------------------------------------------------------------
  // Effective gate selection
  // ---------------------------------------------------------------------
  // Deep-sleep gating is outside this block, so in deep sleep the run
  // register stands in; the sleep register never reaches that state.
  always_comb
  begin
    eff_gate = st_q.run_gate;
    if (st_q.mode == SPCG_SLEEP && st_q.auto_clock_gating_select)
    begin
      eff_gate = st_q.sleep_gate;
    end
    // Without auto-gating the run settings stay in force.
  end

  // ---------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    hit     = 1'b1;
    case (avs_address)
      SPCG_RUN_GATE_OFS:   rd_word[NPORT-1:0] = st_q.run_gate;
      SPCG_SLEEP_GATE_OFS: rd_word[NPORT-1:0] = st_q.sleep_gate;
      SPCG_CLK_CFG_OFS:    rd_word[SPCG_ACG_BIT] = st_q.auto_clock_gating_select;
      SPCG_MODE_OFS:       rd_word[1:0] = st_q.mode;
      SPCG_IRQ_STAT_OFS:   rd_word[SPCG_IRQ_BITS-1:0] = st_q.stat;
      SPCG_IRQ_MASK_OFS:   rd_word[SPCG_IRQ_BITS-1:0] = st_q.mask;
      default:             hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    st_d       = st_q;
    st_d.ack   = req;
    st_d.rdata = 32'h00000000;
    st_d.resp  = 2'h0;
    if (req)
    begin
      st_d.resp = hit ? 2'h0 : 2'h2;
      if (avs_read)
      begin
        st_d.rdata = rd_word;
      end
    end
    if (wr_lane0)
    begin
      case (avs_address)
        SPCG_RUN_GATE_OFS:
          st_d.run_gate = avs_writedata[NPORT-1:0];
        SPCG_SLEEP_GATE_OFS:
          st_d.sleep_gate = avs_writedata[NPORT-1:0];
        SPCG_MODE_OFS:
          if (avs_writedata[1:0] != 2'b11)
          begin
            st_d.mode = spcg_mode_t'(avs_writedata[1:0]);
          end
        SPCG_IRQ_MASK_OFS:
          st_d.mask = avs_writedata[SPCG_IRQ_BITS-1:0];
        default:
          st_d.mask = st_q.mask;
      endcase
    end
    if (wr_lane3 && avs_address == SPCG_CLK_CFG_OFS)
    begin
      st_d.auto_clock_gating_select = avs_writedata[SPCG_ACG_BIT];
    end
    // Read clears status; a new event in the same cycle wins.
    if (req && avs_read && avs_address == SPCG_IRQ_STAT_OFS)
    begin
      st_d.stat = '0;
    end
    if (guard_fault)
    begin
      st_d.stat[SPCG_IRQ_FAULT_BIT] = 1'b1;
    end
    if (st_d.mode != st_q.mode)
    begin
      st_d.stat[SPCG_IRQ_MODE_BIT] = 1'b1;
    end
    st_d.gate = eff_gate;
    st_d.irq  = |(st_d.stat & st_d.mask);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_q            <= '0;
      st_q.run_gate   <= SPCG_GATE_RESET[NPORT-1:0];
      st_q.sleep_gate <= SPCG_GATE_RESET[NPORT-1:0];
      st_q.mode       <= spcg_mode_t'(SPCG_MODE_RESET);
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------
  // Port guard
  // ---------------------------------------------------------------------
  spcg_port_guard #(
    .NPORT       (NPORT)
  ) u_guard (
    .clock       (clock),
    .reset       (reset),
    .gate_en     (st_q.gate),
    .port_access (port_access),
    .port_clk_en (guard_en),
    .fault       (guard_fault)
  );

  assign avs_waitrequest = ~st_q.ack;
  assign avs_readdata    = st_q.rdata;
  assign avs_response    = st_q.resp;
  assign port_clk_en     = guard_en;
  assign port_bus_fault  = guard_fault;
  assign irq             = st_q.irq;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_sleep_gate;
    @(posedge clock) disable iff (reset)
      (st_q.mode == SPCG_SLEEP && st_q.auto_clock_gating_select && $stable(st_q.sleep_gate)
       && $stable(st_q.mode) && $stable(st_q.auto_clock_gating_select))
      |-> ##2 port_clk_en == $past(st_q.sleep_gate, 2);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("Sleep gate not applied to port clocks.");

  property p_clear_stops;
    @(posedge clock) disable iff (reset)
      (st_q.gate == '0) |=> port_clk_en == '0;
  endproperty
  a_clear_stops: assert property (p_clear_stops)
    else $error("Gated port still clocked.");

  property p_fault;
    @(posedge clock) disable iff (reset)
      (|(port_access & ~port_clk_en)) |=> port_bus_fault;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Access to stopped port gave no fault.");

  property p_reset_zero;
    @(posedge clock)
      $fell(reset) |-> st_q.sleep_gate == '0 && port_clk_en == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Gate bits not zero after reset.");

  property p_upper_zero;
    @(posedge clock) disable iff (reset)
      (req && avs_read && avs_address == SPCG_SLEEP_GATE_OFS)
      |=> avs_readdata[31:NPORT] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Reserved bits read nonzero.");

  property p_run_mode;
    @(posedge clock) disable iff (reset)
      (st_q.mode == SPCG_RUN) |=> st_q.gate == $past(st_q.run_gate);
  endproperty
  a_run_mode: assert property (p_run_mode)
    else $error("Run mode not using run gate.");

  property p_acg;
    @(posedge clock) disable iff (reset)
      (st_q.mode == SPCG_SLEEP && st_q.auto_clock_gating_select)
      |=> st_q.gate == $past(st_q.sleep_gate);
  endproperty
  a_acg: assert property (p_acg)
    else $error("Sleep gate ignored with auto-gating set.");

  property p_no_acg;
    @(posedge clock) disable iff (reset)
      (st_q.mode == SPCG_SLEEP && !st_q.auto_clock_gating_select)
      |=> st_q.gate == $past(st_q.run_gate);
  endproperty
  a_no_acg: assert property (p_no_acg)
    else $error("Run gate not kept without auto-gating.");

  property p_ack_one;
    @(posedge clock) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("Bus request not answered in one cycle.");

  property p_wait_idle;
    @(posedge clock) disable iff (reset)
      !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("Answer given without a request.");

  property p_rdata_idle;
    @(posedge clock) disable iff (reset)
      avs_waitrequest |-> avs_readdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside an answer.");

  property p_resp_idle;
    @(posedge clock) disable iff (reset)
      avs_waitrequest |-> avs_response == 2'h0;
  endproperty
  a_resp_idle: assert property (p_resp_idle)
    else $error("Response not okay outside an answer.");

  property p_gate_follows;
    @(posedge clock) disable iff (reset)
      1'b1 |=> port_clk_en == $past(st_q.gate);
  endproperty
  a_gate_follows: assert property (p_gate_follows)
    else $error("Port clocks do not follow the selected gate.");

  property p_no_fault;
    @(posedge clock) disable iff (reset)
      ((port_access & ~port_clk_en) == '0) |=> !port_bus_fault;
  endproperty
  a_no_fault: assert property (p_no_fault)
    else $error("Fault raised for a clocked port.");

  property p_fault_stat;
    @(posedge clock) disable iff (reset)
      port_bus_fault |=> st_q.stat[SPCG_IRQ_FAULT_BIT];
  endproperty
  a_fault_stat: assert property (p_fault_stat)
    else $error("Fault did not set its status bit.");

  property p_irq_level;
    @(posedge clock) disable iff (reset)
      irq == |(st_q.stat & st_q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt level disagrees with status and mask.");

  property p_mode_legal;
    @(posedge clock) disable iff (reset)
      st_q.mode != spcg_mode_t'(2'b11);
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("Power mode holds an unused code.");

  property p_sleep_hold;
    @(posedge clock) disable iff (reset)
      !(wr_lane0 && avs_address == SPCG_SLEEP_GATE_OFS)
      |=> $stable(st_q.sleep_gate);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("Sleep gate changed without a write.");

  property p_deep_run;
    @(posedge clock) disable iff (reset)
      (st_q.mode == SPCG_DEEP_SLEEP) |=> st_q.gate == $past(st_q.run_gate);
  endproperty
  a_deep_run: assert property (p_deep_run)
    else $error("Sleep gate used outside sleep.");

  property p_stat_clear;
    @(posedge clock) disable iff (reset)
      (req && avs_read && avs_address == SPCG_IRQ_STAT_OFS
       && !port_bus_fault) |=> st_q.stat == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("Status not cleared by its read.");

endmodule : spcg_top

// file: src/spcg_pkg.sv
package spcg_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [11:0] SPCG_RUN_GATE_OFS   = 12'h108;
  localparam logic [11:0] SPCG_SLEEP_GATE_OFS = 12'h118;
  localparam logic [11:0] SPCG_CLK_CFG_OFS    = 12'h060;
  localparam logic [11:0] SPCG_MODE_OFS       = 12'h200;
  localparam logic [11:0] SPCG_IRQ_STAT_OFS   = 12'h204;
  localparam logic [11:0] SPCG_IRQ_MASK_OFS   = 12'h208;

  // ---------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------
  localparam int          SPCG_NUM_PORTS      = 8;
  localparam int          SPCG_ACG_BIT        = 27;
  localparam logic [7:0]  SPCG_GATE_RESET     = 8'h00;
  localparam logic [1:0]  SPCG_MODE_RESET     = 2'h0;
  localparam int          SPCG_IRQ_FAULT_BIT  = 0;
  localparam int          SPCG_IRQ_MODE_BIT   = 1;
  localparam int          SPCG_IRQ_BITS       = 2;

  // ---------------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPCG_RUN        = 2'b00,
    SPCG_SLEEP      = 2'b01,
    SPCG_DEEP_SLEEP = 2'b10
  } spcg_mode_t;

endpackage : spcg_pkg

// file: src/spcg_port_guard.sv
`timescale 1ns/1ns
module spcg_port_guard
  import spcg_pkg::*;
#(
  parameter int NPORT = SPCG_NUM_PORTS
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [NPORT-1:0] gate_en,
  input  wire logic [NPORT-1:0] port_access,
  output logic      [NPORT-1:0] port_clk_en,
  output logic                  fault
);

  typedef struct packed {
    logic [NPORT-1:0] en;
    logic             fault;
  } spcg_guard_t;

  spcg_guard_t st_q;
  spcg_guard_t st_d;

  always_comb
  begin
    st_d       = st_q;
    st_d.en    = gate_en;
    // An access to a stopped port is flagged instead of served.
    st_d.fault = |(port_access & ~st_q.en);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign port_clk_en = st_q.en;
  assign fault       = st_q.fault;

endmodule : spcg_port_guard

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import spcg_pkg::*;
;
  logic        clock;
  logic        reset;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [7:0]  port_access;
  logic [7:0]  port_clk_en;
  logic        port_bus_fault;
  logic        irq;
  logic [31:0] rd;
  int          miscompares;
  int          total_checks;
  int          rg, sg, auto_clock_gating_select, md, msk, st, pa, eff, flt;

  spcg_top spcg_top_i (
    .clock           (clock),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .avs_response    (avs_response),
    .port_access     (port_access),
    .port_clk_en     (port_clk_en),
    .port_bus_fault  (port_bus_fault),
    .irq             (irq)
  );

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Starts one edge late so a release is never overwritten in its own step.
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [1:0] er);
    int n;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
    begin
      miscompares++;
      wrap_up();
    end
    rd = avs_readdata;
    chk("response", {30'h0, avs_response}, {30'h0, er});
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial
  begin
    reset = 1'b1;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    port_access = 8'h00;
    miscompares = 0;
    total_checks = 0;
    md = 0;
    rg = $urandom(52);
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, SPCG_SLEEP_GATE_OFS, 32'h0, 2'h0);
    chk("sleep_reset", rd, 32'h0);
    chk("clk_en_reset", port_clk_en, 8'h00);
    bus(1'b1, SPCG_SLEEP_GATE_OFS, 32'hffffffff, 2'h0);
    bus(1'b0, SPCG_SLEEP_GATE_OFS, 32'h0, 2'h0);
    chk("sleep_reserved", rd, 32'h000000ff);
    bus(1'b1, 12'h3fc, 32'hffffffff, 2'h2);
    bus(1'b0, 12'h3fc, 32'h0, 2'h2);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, SPCG_MODE_OFS, 32'h3, 2'h0);
    bus(1'b0, SPCG_MODE_OFS, 32'h0, 2'h0);
    chk("mode_ignored", rd, 32'h0);
    for (int i = 0; i < 14; i++)
    begin
      rg  = $urandom & 255;
      sg  = $urandom & 255;
      auto_clock_gating_select = $urandom & 1;
      msk = (i < 4) ? 0 : ($urandom & 3);
      md  = (md + 1 + $urandom % 2) % 3;
      pa  = $urandom & 255;
      bus(1'b1, SPCG_RUN_GATE_OFS, rg, 2'h0);
      bus(1'b1, SPCG_SLEEP_GATE_OFS, sg | 32'hffffff00, 2'h0);
      bus(1'b1, SPCG_CLK_CFG_OFS, auto_clock_gating_select << SPCG_ACG_BIT, 2'h0);
      bus(1'b1, SPCG_IRQ_MASK_OFS, msk, 2'h0);
      bus(1'b1, SPCG_MODE_OFS, md, 2'h0);
      st  = 2;
      eff = (md == 1 && auto_clock_gating_select == 1) ? sg : rg;
      repeat (3) @(posedge clock);
      chk("clk_en", port_clk_en, eff);
      port_access <= pa[7:0];
      @(posedge clock);
      port_access <= 8'h00;
      @(posedge clock);
      flt = ((pa & ~eff & 255) != 0);
      chk("fault", port_bus_fault, flt);
      if (flt == 1)
        st = 3;
      @(posedge clock);
      chk("irq", irq, (st & msk) != 0);
      bus(1'b0, SPCG_IRQ_STAT_OFS, 32'h0, 2'h0);
      chk("status", rd, st);
      bus(1'b0, SPCG_SLEEP_GATE_OFS, 32'h0, 2'h0);
      chk("sleep_gate", rd, sg);
    end
    // A second reset in mid-run must drop every port clock again.
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk("clk_en_rst2", port_clk_en, 8'h00);
    bus(1'b0, SPCG_SLEEP_GATE_OFS, 32'h0, 2'h0);
    chk("sleep_rst2", rd, 32'h0);
    wrap_up();
  end
endmodule : tb_top
